// ### rtl/cfg_regs_pkg.sv
package cfg_regs_pkg;

   // Register port geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int DIV_W  = 10;
   localparam int VER_W  = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] SERIAL_PORT_CONFIG_OFS      = 12'h000;
   localparam logic [ADDR_W-1:0] READBACK_CONTROL_OFS        = 12'h004;
   localparam logic [ADDR_W-1:0] CUSTOMER_VERSION_LOW_OFS    = 12'h005;
   localparam logic [ADDR_W-1:0] CUSTOMER_VERSION_HIGH_OFS   = 12'h006;
   localparam logic [ADDR_W-1:0] FIRST_REF_DIVIDER_LOW_OFS   = 12'h010;
   localparam logic [ADDR_W-1:0] FIRST_REF_DIVIDER_HIGH_OFS  = 12'h011;
   localparam logic [ADDR_W-1:0] SECOND_REF_DIVIDER_LOW_OFS  = 12'h012;
   localparam logic [ADDR_W-1:0] SECOND_REF_DIVIDER_HIGH_OFS = 12'h013;

   // Field positions in serial_port_config (mirrored pairs)
   localparam int CFG_SDO_HI   = 7;
   localparam int CFG_SDO_LO   = 0;
   localparam int CFG_LSB_HI   = 6;
   localparam int CFG_LSB_LO   = 1;
   localparam int CFG_SRST_HI  = 5;
   localparam int CFG_SRST_LO  = 2;
   // Field position in readback_control
   localparam int RB_ACTIVE    = 0;
   // Width of the divider field held in a high register
   localparam int DIV_HI_W     = 2;

   // Values after reset
   localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;
   localparam logic [DIV_W-1:0]  DIV_RESET_VAL = 10'h000;
   localparam logic [VER_W-1:0]  VER_RESET_VAL = 16'h0000;

endpackage

// ### rtl/mode_pin_sync.sv
`timescale 1ns/1ps
module mode_pin_sync (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Asynchronous level in, synchronised level out
   input  wire logic pin_async,
   output logic      pin_sync
);
   typedef struct packed {
      logic meta;
      logic sync;
   } sync_state_s;

   sync_state_s state_ff;
   sync_state_s nxt_state;

   // Plain two-stage chain; first stage feeds only the second
   always_comb begin
      nxt_state.meta = pin_async;
      nxt_state.sync = state_ff.meta;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign pin_sync = state_ff.sync;
endmodule

// ### rtl/clock_chip_config_registers.sv
`timescale 1ns/1ps
// What this block does
// - Writes to addresses outside the map change nothing inside the block.
// - SPI mode config register mirrors SDO, LSB-first, soft reset; bits 4,3 reserved.
// - I2C mode config writes change only soft reset bits 5 and 2; other bits hold.
// - Readback control bit 0 selects active values; other bits reserved, reset zero.
// - Sixteen-bit customer version, low byte then high byte, both reset zero.
module clock_chip_config_registers (
   // Clock and reset
   input  wire logic                            sys_clk,
   input  wire logic                            sys_rst,
   // Serial port mode pin, high selects I2C
   input  wire logic                            i2c_mode_pin,
   // Register port from the serial protocol engine
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   input  wire logic [cfg_regs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [cfg_regs_pkg::DATA_W-1:0] reg_wdata,
   output logic      [cfg_regs_pkg::DATA_W-1:0] reg_rdata,
   output logic                                 reg_rvalid,
   // Transfer of buffered values into the active set
   input  wire logic                            update_req,
   // Controls to the rest of the device
   output logic                                 sdo_enable,
   output logic                                 lsb_first,
   output logic                                 soft_reset,
   output logic [cfg_regs_pkg::VER_W-1:0]       customer_version,
   output logic [cfg_regs_pkg::DIV_W-1:0]       first_reference_input_div,
   output logic [cfg_regs_pkg::DIV_W-1:0]       second_reference_input_div
);
   import cfg_regs_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] cfg;
      logic [DATA_W-1:0] rb_ctl;
      logic [DATA_W-1:0] ver_lo;
      logic [DATA_W-1:0] ver_hi;
      logic [DATA_W-1:0] div1_lo;
      logic [DATA_W-1:0] div1_hi;
      logic [DATA_W-1:0] div2_lo;
      logic [DATA_W-1:0] div2_hi;
      logic [VER_W-1:0]  act_ver;
      logic [DIV_W-1:0]  act_div1;
      logic [DIV_W-1:0]  act_div2;
      logic [DATA_W-1:0] rdata;
      logic              rvalid;
   } bank_state_s;

   bank_state_s state_ff;
   bank_state_s nxt_state;
   logic        i2c_mode;
   logic        srst_busy;
   logic        sdo_w;
   logic        lsb_w;
   logic        srst_w;

   ////////////////////////////////////////////////////////////////////////
   // Mode pin comes from outside, so it is synchronised first
   mode_pin_sync u_mode_sync (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .pin_async (i2c_mode_pin),
      .pin_sync  (i2c_mode)
   );

   // Either half of a mirrored pair sets the control
   assign sdo_w     = reg_wdata[CFG_SDO_HI] | reg_wdata[CFG_SDO_LO];
   assign lsb_w     = reg_wdata[CFG_LSB_HI] | reg_wdata[CFG_LSB_LO];
   assign srst_w    = reg_wdata[CFG_SRST_HI] | reg_wdata[CFG_SRST_LO];
   assign srst_busy = state_ff.cfg[CFG_SRST_HI] | state_ff.cfg[CFG_SRST_LO];

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: soft reset, writes, update, reads
   always_comb begin
      nxt_state        = state_ff;
      nxt_state.rvalid = 1'b0;
      if (srst_busy) begin
         // Soft reset returns every register to default, its own bits too
         nxt_state = '0;
      end else begin
         if (reg_wr) begin
            unique case (reg_addr)
               SERIAL_PORT_CONFIG_OFS: begin
                  if (i2c_mode) begin
                     // Only the soft reset pair is live in I2C mode
                     nxt_state.cfg[CFG_SRST_HI] = srst_w;
                     nxt_state.cfg[CFG_SRST_LO] = srst_w;
                  end else begin
                     // Store mirrored so both halves always read alike
                     nxt_state.cfg = {sdo_w, lsb_w, srst_w, 2'b00, srst_w, lsb_w, sdo_w};
                  end
               end
               READBACK_CONTROL_OFS: begin
                  // Reserved bits held at default whatever the host sends
                  nxt_state.rb_ctl = {7'h00, reg_wdata[RB_ACTIVE]};
               end
               CUSTOMER_VERSION_LOW_OFS:   nxt_state.ver_lo  = reg_wdata;
               CUSTOMER_VERSION_HIGH_OFS:  nxt_state.ver_hi  = reg_wdata;
               FIRST_REF_DIVIDER_LOW_OFS:  nxt_state.div1_lo = reg_wdata;
               FIRST_REF_DIVIDER_HIGH_OFS: nxt_state.div1_hi = {6'h00, reg_wdata[DIV_HI_W-1:0]};
               SECOND_REF_DIVIDER_LOW_OFS: nxt_state.div2_lo = reg_wdata;
               SECOND_REF_DIVIDER_HIGH_OFS: nxt_state.div2_hi = {6'h00, reg_wdata[DIV_HI_W-1:0]};
               default: ; // Unmapped address: nothing changes
            endcase
         end
         // Update copies the buffered set, including any write this cycle
         if (update_req) begin
            nxt_state.act_ver  = {nxt_state.ver_hi, nxt_state.ver_lo};
            nxt_state.act_div1 = {nxt_state.div1_hi[DIV_HI_W-1:0], nxt_state.div1_lo};
            nxt_state.act_div2 = {nxt_state.div2_hi[DIV_HI_W-1:0], nxt_state.div2_lo};
         end
         // Reads return buffer or active values per readback control
         if (reg_rd) begin
            nxt_state.rvalid = 1'b1;
            unique case (reg_addr)
               SERIAL_PORT_CONFIG_OFS:    nxt_state.rdata = state_ff.cfg;
               READBACK_CONTROL_OFS:      nxt_state.rdata = state_ff.rb_ctl;
               CUSTOMER_VERSION_LOW_OFS:  nxt_state.rdata = state_ff.rb_ctl[RB_ACTIVE] ?
                                                           state_ff.act_ver[7:0] : state_ff.ver_lo;
               CUSTOMER_VERSION_HIGH_OFS: nxt_state.rdata = state_ff.rb_ctl[RB_ACTIVE] ?
                                                           state_ff.act_ver[15:8] : state_ff.ver_hi;
               FIRST_REF_DIVIDER_LOW_OFS: nxt_state.rdata = state_ff.rb_ctl[RB_ACTIVE] ?
                                                           state_ff.act_div1[7:0] : state_ff.div1_lo;
               FIRST_REF_DIVIDER_HIGH_OFS: nxt_state.rdata = state_ff.rb_ctl[RB_ACTIVE] ?
                                                            {6'h00, state_ff.act_div1[9:8]} : state_ff.div1_hi;
               SECOND_REF_DIVIDER_LOW_OFS: nxt_state.rdata = state_ff.rb_ctl[RB_ACTIVE] ?
                                                            state_ff.act_div2[7:0] : state_ff.div2_lo;
               SECOND_REF_DIVIDER_HIGH_OFS: nxt_state.rdata = state_ff.rb_ctl[RB_ACTIVE] ?
                                                             {6'h00, state_ff.act_div2[9:8]} : state_ff.div2_hi;
               default: nxt_state.rdata = REG_RESET_VAL; // Unmapped reads as zero
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Single state register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs from flip-flops; sdo_enable and lsb_first masked by i2c_mode, soft_reset ORs its pair
   assign reg_rdata                  = state_ff.rdata;
   assign reg_rvalid                 = state_ff.rvalid;
   assign sdo_enable                 = state_ff.cfg[CFG_SDO_LO] & ~i2c_mode;
   assign lsb_first                  = state_ff.cfg[CFG_LSB_LO] & ~i2c_mode;
   assign soft_reset                 = srst_busy;
   assign customer_version           = state_ff.act_ver;
   assign first_reference_input_div  = state_ff.act_div1;
   assign second_reference_input_div = state_ff.act_div2;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic mapped;
   assign mapped = (reg_addr == SERIAL_PORT_CONFIG_OFS)      || (reg_addr == READBACK_CONTROL_OFS)
                || (reg_addr == CUSTOMER_VERSION_LOW_OFS)    || (reg_addr == CUSTOMER_VERSION_HIGH_OFS)
                || (reg_addr == FIRST_REF_DIVIDER_LOW_OFS)   || (reg_addr == FIRST_REF_DIVIDER_HIGH_OFS)
                || (reg_addr == SECOND_REF_DIVIDER_LOW_OFS)  || (reg_addr == SECOND_REF_DIVIDER_HIGH_OFS);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_unmapped_write: assert property (
      reg_wr && !mapped && !srst_busy && !update_req |=>
         $stable({state_ff.cfg, state_ff.rb_ctl, state_ff.ver_lo, state_ff.ver_hi,
                  state_ff.div1_lo, state_ff.div1_hi, state_ff.div2_lo, state_ff.div2_hi,
                  state_ff.act_ver, state_ff.act_div1, state_ff.act_div2}))
      else $error("unmapped write changed a register");
   chk_spi_mirror: assert property (
      !i2c_mode && reg_wr && reg_addr == SERIAL_PORT_CONFIG_OFS && !srst_busy |=>
         state_ff.cfg[7] == state_ff.cfg[0] && state_ff.cfg[6] == state_ff.cfg[1]
         && state_ff.cfg[4:3] == 2'b00 && state_ff.cfg[0] == $past(reg_wdata[7] | reg_wdata[0]))
      else $error("config register not mirrored");
   chk_i2c_keeps_srst: assert property (
      i2c_mode && reg_wr && reg_addr == SERIAL_PORT_CONFIG_OFS && !srst_busy |=>
         state_ff.cfg[5] == $past(reg_wdata[5] | reg_wdata[2])
         && state_ff.cfg[1:0] == $past(state_ff.cfg[1:0]) && state_ff.cfg[7:6] == $past(state_ff.cfg[7:6]))
      else $error("i2c config write touched non soft reset bits");
   chk_readback_select: assert property (
      reg_rd && reg_addr == FIRST_REF_DIVIDER_LOW_OFS && state_ff.rb_ctl[0] && !srst_busy |=>
         reg_rvalid && reg_rdata == $past(state_ff.act_div1[7:0]) && state_ff.rb_ctl[7:1] == 7'h00)
      else $error("readback did not return active value");
   chk_version_bytes: assert property (
      reg_wr && reg_addr == CUSTOMER_VERSION_HIGH_OFS && !srst_busy ##1 !reg_wr && !srst_busy
         ##1 update_req && !reg_wr && !srst_busy
         |=> customer_version[15:8] == $past(reg_wdata, 3))
      else $error("version high byte not in bits 15..8");
   chk_first_div_split: assert property (
      reg_wr && reg_addr == FIRST_REF_DIVIDER_HIGH_OFS && !srst_busy |=>
         state_ff.div1_hi == {6'h00, $past(reg_wdata[1:0])})
      else $error("first divider high register wrong");
   chk_second_div_split: assert property (
      update_req && !reg_wr && !srst_busy |=>
         second_reference_input_div == {$past(state_ff.div2_hi[1:0]), $past(state_ff.div2_lo)})
      else $error("second divider not assembled from two registers");
   chk_soft_clear: assert property (
      reg_wr && reg_addr == SERIAL_PORT_CONFIG_OFS && !srst_busy && (reg_wdata[5] | reg_wdata[2])
         |=> soft_reset ##1 (!soft_reset && state_ff.cfg == 8'h00 && first_reference_input_div == 10'h000))
      else $error("soft reset did not clear itself");

   cov_spi_cfg_write: cover property (!i2c_mode && reg_wr && reg_addr == SERIAL_PORT_CONFIG_OFS);
   cov_update_then_read: cover property (update_req ##1 reg_rd && state_ff.rb_ctl[0]);
   cov_soft_reset: cover property (soft_reset);
   cov_unmapped_write: cover property (reg_wr && !mapped);
endmodule

// ### verif/host_model.sv
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic                            sys_clk,
   // Requests towards the register bank
   output logic                                 reg_wr,
   output logic                                 reg_rd,
   output logic      [cfg_regs_pkg::ADDR_W-1:0] reg_addr,
   output logic      [cfg_regs_pkg::DATA_W-1:0] reg_wdata,
   output logic                                 update_req,
   // Read answer
   input  wire logic [cfg_regs_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                            reg_rvalid
);
   import cfg_regs_pkg::*;

   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      update_req = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One byte write; callers leave reserved bits at zero, never touch them
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;   // Stale data must not pass for a held value
   endtask

   // One byte read, bounded wait for the answer pulse
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      int n;
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(negedge sys_clk);
         n++;
      end
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask

   // Copy buffered values into the active set
   task automatic upd();
      @(negedge sys_clk);
      update_req = 1'b1;
      @(negedge sys_clk);
      update_req = 1'b0;
   endtask
endmodule

// ### verif/tb_clock_chip_config_registers.sv
`timescale 1ns/1ps
module tb_clock_chip_config_registers;
   import cfg_regs_pkg::*;

   logic                sys_clk;
   logic                sys_rst;
   logic                i2c_mode_pin;
   logic                reg_wr;
   logic                reg_rd;
   logic                update_req;
   logic [ADDR_W-1:0]   reg_addr;
   logic [DATA_W-1:0]   reg_wdata;
   logic [DATA_W-1:0]   reg_rdata;
   logic                reg_rvalid;
   logic                sdo_enable;
   logic                lsb_first;
   logic                soft_reset;
   logic [VER_W-1:0]    customer_version;
   logic [DIV_W-1:0]    first_div;
   logic [DIV_W-1:0]    second_div;
   logic [DATA_W-1:0]   rv;
   int                  mismatches;
   int                  n_checks;
   int                  n_srst;
   localparam logic [ADDR_W-1:0] MAP [8] = '{12'h000, 12'h004, 12'h005, 12'h006, 12'h010, 12'h011, 12'h012, 12'h013};

   clock_chip_config_registers DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .i2c_mode_pin(i2c_mode_pin),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .update_req(update_req), .sdo_enable(sdo_enable), .lsb_first(lsb_first),
      .soft_reset(soft_reset), .customer_version(customer_version), .first_reference_input_div(first_div),
      .second_reference_input_div(second_div));

   host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .update_req(update_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   ////////////////////////////////////////////////////////////////////////////
   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Soft reset pulses counted off the sampling edge
   always @(negedge sys_clk) begin
      if (soft_reset === 1'b1) n_srst++;
   end

   // Wide enough for the joined divider and version words
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog, far beyond the hundred or so cycles the tests need
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      mismatches = 0;
      n_checks = 0;
      n_srst = 0;
      sys_rst = 1'b1;
      i2c_mode_pin = 1'b0;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge sys_clk);
      // Every mapped byte starts at zero
      foreach (MAP[i]) begin
         host.rd(MAP[i], rv);
         check("reset value", rv, 8'h00);
      end
      $display("test reset_values done");
      // Mirrored pairs: either bit sets both
      host.wr(12'h000, 8'h01);
      host.rd(12'h000, rv);
      check("cfg sdo pair", rv, 8'h81);
      check("sdo_enable", sdo_enable, 1);
      host.wr(12'h000, 8'h40);
      host.rd(12'h000, rv);
      check("cfg lsb pair", rv, 8'h42);
      check("lsb_first", {sdo_enable, lsb_first}, 2'b01);
      host.wr(12'h000, 8'hC3);
      $display("test spi_config done");
      // Buffered version and dividers, then transfer to active set
      host.wr(12'h005, 8'hA5);
      host.wr(12'h010, 8'h34);
      host.wr(12'h011, 8'h02);
      host.wr(12'h012, 8'hCD);
      host.wr(12'h013, 8'h01);
      // High byte last, so its write sits two cycles before the update
      host.wr(12'h006, 8'h3C);
      check("version before update", customer_version, 16'h0000);
      host.upd();
      check("customer_version", customer_version, 16'h3CA5);
      check("first div", first_div, 10'h234);
      check("second div", second_div, 10'h1CD);
      host.rd(12'h011, rv);
      check("first div high", rv, 8'h02);
      host.rd(12'h013, rv);
      check("second div high", rv, 8'h01);
      // Readback source select
      host.wr(12'h005, 8'h11);
      host.wr(12'h010, 8'h99);
      host.wr(12'h004, 8'h01);
      host.rd(12'h004, rv);
      check("readback ctl", rv, 8'h01);
      host.rd(12'h005, rv);
      check("active version low", rv, 8'hA5);
      host.rd(12'h010, rv);
      check("active div low", rv, 8'h34);
      host.wr(12'h004, 8'h00);
      host.rd(12'h005, rv);
      check("buffer version low", rv, 8'h11);
      $display("test dividers_version done");
      // Unmapped writes leave everything alone
      host.wr(12'h007, 8'h55);
      host.wr(12'h014, 8'h77);
      host.wr(12'h100, 8'hFF);
      host.rd(12'h007, rv);
      check("unmapped read", rv, 8'h00);
      host.rd(12'h010, rv);
      check("first div low kept", rv, 8'h99);
      host.rd(12'h000, rv);
      check("cfg kept", rv, 8'hC3);
      check("active kept", {first_div, customer_version}, {10'h234, 16'h3CA5});
      $display("test unmapped done");
      // I2C mode hides the SPI-only controls
      @(negedge sys_clk);
      i2c_mode_pin = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("i2c sdo/lsb", {sdo_enable, lsb_first}, 2'b00);
      // Soft reset from I2C: one pulse, then everything back to zero
      host.wr(12'h000, 8'h20);
      repeat (3) @(negedge sys_clk);
      check("soft reset pulses", n_srst[15:0], 16'h0001);
      host.rd(12'h000, rv);
      check("cfg after soft reset", rv, 8'h00);
      host.rd(12'h005, rv);
      check("version after soft reset", rv, 8'h00);
      check("active after soft reset", {first_div, second_div}, 20'h0);
      $display("test soft_reset done");
      tally_and_finish();
   end
endmodule
